/* hdl/lsel_pkg.sv */
// Constants and types shared by the LED source selector
package lsel_pkg;
    // Register byte addresses on the AHB-Lite slave
    localparam logic [7:0] LSEL_ADDR_CTRL = 8'h00;
    localparam logic [7:0] LSEL_ADDR_STAT = 8'h04;
    localparam int LSEL_ADDR_W = 8;
    // Per-LED lane of the control register
    localparam int LSEL_LANE_W = 8;
    localparam int LSEL_FLD_MODE_LSB = 0;
    localparam int LSEL_FLD_MODE_W = 4;
    localparam int LSEL_FLD_RATE = 5;
    localparam int LSEL_FLD_FLIP = 6;
    localparam int LSEL_FLD_BLINK = 7;
    localparam logic [7:0] LSEL_LANE_WMASK = 8'hEF;
    // Control reset: out0 link up, out1 filtered activity blinking, out2 100M, out3 1000M
    localparam logic [31:0] LSEL_CTRL_RESET = 32'h0706_8302;
    // Status register field positions
    localparam int LSEL_STAT_LED_LSB = 0;
    localparam int LSEL_STAT_LINK = 8;
    localparam int LSEL_STAT_SPD_LSB = 9;
    localparam int LSEL_STAT_FDX = 11;
    localparam int LSEL_STAT_TXACT = 12;
    localparam int LSEL_STAT_RXACT = 13;
    localparam int LSEL_STAT_FILT = 14;
    localparam int LSEL_STAT_COLL = 15;
    localparam int LSEL_STAT_X1 = 16;
    localparam int LSEL_STAT_PAUSE = 17;
    localparam int LSEL_STAT_SLOW = 20;
    localparam int LSEL_STAT_FAST = 21;
    // Link speed codes
    localparam logic [1:0] LSEL_SPD_10 = 2'h0;
    localparam logic [1:0] LSEL_SPD_100 = 2'h1;
    localparam logic [1:0] LSEL_SPD_1000 = 2'h2;
    // Clock and blink timing
    localparam longint unsigned LSEL_CLK_HZ = 64'd20000000;
    localparam longint unsigned LSEL_BLINK_SLOW_MS = 64'd200;
    localparam longint unsigned LSEL_BLINK_FAST_MS = 64'd83;
    localparam int LSEL_SLOW_HALF_CYC = int'(LSEL_BLINK_SLOW_MS * LSEL_CLK_HZ / 64'd1000);
    localparam int LSEL_FAST_HALF_CYC = int'(LSEL_BLINK_FAST_MS * LSEL_CLK_HZ / 64'd1000);
    // AHB transfer type bit that marks NONSEQ or SEQ
    localparam int LSEL_HTRANS_ACTIVE = 1;

    // Source selection codes per LED
    typedef enum logic [3:0] {
        LSEL_M_LINK_10_1000 = 4'h0,
        LSEL_M_LINK_100_1000 = 4'h1,
        LSEL_M_LINK_UP = 4'h2,
        LSEL_M_FILT_ACT = 4'h3,
        LSEL_M_LINK_IDLE = 4'h4,
        LSEL_M_LINK_10 = 4'h5,
        LSEL_M_LINK_100 = 4'h6,
        LSEL_M_LINK_1000 = 4'h7,
        LSEL_M_RESERVED = 4'h8,
        LSEL_M_FULL_DUPLEX = 4'h9,
        LSEL_M_COLLISION = 4'hA,
        LSEL_M_ACTIVITY = 4'hB,
        LSEL_M_BUS_X1 = 4'hC,
        LSEL_M_PAUSED = 4'hD,
        LSEL_M_CONST_HIGH = 4'hE,
        LSEL_M_CONST_LOW = 4'hF
    } lsel_mode_t;
endpackage

/* hdl/lsel_blink_timer.sv */
// Free-running blink phase generator for the two blink rates
`timescale 1ns/10ps
module lsel_blink_timer
    import lsel_pkg::*;
#(
    parameter int SLOW_HALF = LSEL_SLOW_HALF_CYC,
    parameter int FAST_HALF = LSEL_FAST_HALF_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    output logic slow_phase,
    output logic fast_phase
);
    // Refuse half periods the counters cannot serve
    if (SLOW_HALF < 1 || FAST_HALF < 1) begin : g_bad_half
        $error("blink half period must be at least one cycle");
    end

    logic [31:0] slow_cnt;
    logic [31:0] fast_cnt;
    logic [31:0] next_slow_cnt;
    logic [31:0] next_fast_cnt;
    logic next_slow_phase;
    logic next_fast_phase;

    // Each counter wraps after one half period and flips its phase
    always_comb begin
        next_slow_cnt = slow_cnt + 32'h1;
        next_slow_phase = slow_phase;
        if (slow_cnt == 32'(SLOW_HALF - 1)) begin
            next_slow_cnt = 32'h0;
            next_slow_phase = ~slow_phase;
        end
        next_fast_cnt = fast_cnt + 32'h1;
        next_fast_phase = fast_phase;
        if (fast_cnt == 32'(FAST_HALF - 1)) begin
            next_fast_cnt = 32'h0;
            next_fast_phase = ~fast_phase;
        end
    end

    // Phase registers start in the lit half
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slow_cnt <= 32'h0;
            fast_cnt <= 32'h0;
            slow_phase <= 1'b1;
            fast_phase <= 1'b1;
        end else begin
            slow_cnt <= next_slow_cnt;
            fast_cnt <= next_fast_cnt;
            slow_phase <= next_slow_phase;
            fast_phase <= next_fast_phase;
        end
    end
endmodule

/* hdl/lsel_led_source_select.sv */
// LED source selector with AHB-Lite control and status registers
`timescale 1ns/10ps
module lsel_led_source_select
    import lsel_pkg::*;
#(
    parameter int NUM_LEDS = 4,
    parameter int SLOW_HALF = LSEL_SLOW_HALF_CYC,
    parameter int FAST_HALF = LSEL_FAST_HALF_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic link_up,
    input wire logic [1:0] link_speed,
    input wire logic full_duplex,
    input wire logic tx_active,
    input wire logic rx_active,
    input wire logic filt_active,
    input wire logic collision,
    input wire logic bus_x1,
    input wire logic tx_paused,
    output logic [NUM_LEDS-1:0] led_out
);
    // Four lanes fit one 32-bit control word
    if (NUM_LEDS < 1 || NUM_LEDS * LSEL_LANE_W > 32) begin : g_bad_leds
        $error("NUM_LEDS must lie between 1 and 4");
    end

    localparam int CTRL_W = NUM_LEDS * LSEL_LANE_W;

    // Bus side state
    logic wr_pend;
    logic [LSEL_ADDR_W-1:0] wr_addr;
    logic next_wr_pend;
    logic [LSEL_ADDR_W-1:0] next_wr_addr;
    logic [31:0] next_hrdata;
    logic [31:0] ctrl;
    logic [31:0] next_ctrl;
    logic [31:0] ctrl_view;
    logic [31:0] stat_view;
    logic addr_ok;
    logic slow_phase;
    logic fast_phase;
    logic [NUM_LEDS-1:0] next_led_out;

    // Slave never stalls and never errors
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Address phase is taken when selected, active and the bus is ready
    assign addr_ok = hsel & htrans[LSEL_HTRANS_ACTIVE] & hready;

    // Control word with unused lanes and reserved bits forced to zero
    always_comb begin
        ctrl_view = 32'h0;
        ctrl_view[CTRL_W-1:0] = ctrl[CTRL_W-1:0];
    end

    // Live status: link inputs, blink phases and the pin levels
    always_comb begin
        stat_view = 32'h0;
        stat_view[LSEL_STAT_LED_LSB +: NUM_LEDS] = led_out;
        stat_view[LSEL_STAT_LINK] = link_up;
        stat_view[LSEL_STAT_SPD_LSB +: 2] = link_speed;
        stat_view[LSEL_STAT_FDX] = full_duplex;
        stat_view[LSEL_STAT_TXACT] = tx_active;
        stat_view[LSEL_STAT_RXACT] = rx_active;
        stat_view[LSEL_STAT_FILT] = filt_active;
        stat_view[LSEL_STAT_COLL] = collision;
        stat_view[LSEL_STAT_X1] = bus_x1;
        stat_view[LSEL_STAT_PAUSE] = tx_paused;
        stat_view[LSEL_STAT_SLOW] = slow_phase;
        stat_view[LSEL_STAT_FAST] = fast_phase;
    end

    // Capture writes for their data phase, prepare read data early
    always_comb begin
        next_wr_pend = addr_ok & hwrite;
        next_wr_addr = wr_addr;
        next_ctrl = ctrl;
        next_hrdata = hrdata;
        if (addr_ok) begin
            next_wr_addr = haddr[LSEL_ADDR_W-1:0];
        end
        // Data phase write of the control word, reserved bits dropped
        if (wr_pend && wr_addr == LSEL_ADDR_CTRL) begin
            for (int i = 0; i < NUM_LEDS; i++) begin
                next_ctrl[i*LSEL_LANE_W +: LSEL_LANE_W] =
                    hwdata[i*LSEL_LANE_W +: LSEL_LANE_W] & LSEL_LANE_WMASK;
            end
        end
        // Read data registered at the address phase, forwarding a pending write
        if (addr_ok && !hwrite) begin
            if (haddr[LSEL_ADDR_W-1:0] == LSEL_ADDR_CTRL) begin
                if (wr_pend && wr_addr == LSEL_ADDR_CTRL) begin
                    next_hrdata = 32'h0;
                    next_hrdata[CTRL_W-1:0] = next_ctrl[CTRL_W-1:0];
                end else begin
                    next_hrdata = ctrl_view;
                end
            end else if (haddr[LSEL_ADDR_W-1:0] == LSEL_ADDR_STAT) begin
                next_hrdata = stat_view;
            end else begin
                next_hrdata = 32'h0;
            end
        end
    end

    // Bus side registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            ctrl <= LSEL_CTRL_RESET;
            hrdata <= 32'h0;
        end else begin
            wr_pend <= next_wr_pend;
            wr_addr <= next_wr_addr;
            ctrl <= next_ctrl;
            hrdata <= next_hrdata;
        end
    end

    // Shared blink phases for both rates
    lsel_blink_timer #(
        .SLOW_HALF(SLOW_HALF),
        .FAST_HALF(FAST_HALF)
    ) u_blink (
        .hclk(hclk),
        .hresetn(hresetn),
        .slow_phase(slow_phase),
        .fast_phase(fast_phase)
    );

    // Per-LED source, inversion and blink
    for (genvar g = 0; g < NUM_LEDS; g++) begin : g_led
        lsel_mode_t sel;
        logic rate;
        logic flip;
        logic blink_en;
        logic src;
        logic shaped;
        logic at10;
        logic at100;
        logic at1000;
        logic traffic;

        assign sel = lsel_mode_t'(ctrl[g*LSEL_LANE_W + LSEL_FLD_MODE_LSB +: LSEL_FLD_MODE_W]);
        assign rate = ctrl[g*LSEL_LANE_W + LSEL_FLD_RATE];
        assign flip = ctrl[g*LSEL_LANE_W + LSEL_FLD_FLIP];
        assign blink_en = ctrl[g*LSEL_LANE_W + LSEL_FLD_BLINK];
        assign at10 = link_up & (link_speed == LSEL_SPD_10);
        assign at100 = link_up & (link_speed == LSEL_SPD_100);
        assign at1000 = link_up & (link_speed == LSEL_SPD_1000);
        assign traffic = tx_active | rx_active;

        // Source selection by mode code
        always_comb begin
            case (sel)
                LSEL_M_LINK_10_1000: src = at10 | at1000;
                LSEL_M_LINK_100_1000: src = at100 | at1000;
                LSEL_M_LINK_UP: src = link_up;
                LSEL_M_FILT_ACT: src = link_up & filt_active;
                LSEL_M_LINK_IDLE: src = link_up & ~traffic;
                LSEL_M_LINK_10: src = at10;
                LSEL_M_LINK_100: src = at100;
                LSEL_M_LINK_1000: src = at1000;
                LSEL_M_FULL_DUPLEX: src = full_duplex;
                LSEL_M_COLLISION: src = collision;
                LSEL_M_ACTIVITY: src = link_up & traffic;
                LSEL_M_BUS_X1: src = bus_x1;
                LSEL_M_PAUSED: src = tx_paused;
                LSEL_M_CONST_HIGH: src = 1'b1;
                LSEL_M_CONST_LOW: src = 1'b0;
                LSEL_M_RESERVED: src = 1'b0;
                default: src = 1'b0;
            endcase
        end

        // Invert first, then gate the asserted level by the chosen phase
        always_comb begin
            shaped = src ^ flip;
            if (blink_en) begin
                shaped = shaped & (rate ? fast_phase : slow_phase);
            end
            next_led_out[g] = shaped;
        end
    end

    // Pin register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            led_out <= '0;
        end else begin
            led_out <= next_led_out;
        end
    end
endmodule

/* tb/lsel_properties.sv */
// Port-level assertions for the LED source selector
`timescale 1ns/10ps
module lsel_properties
    import lsel_pkg::*;
#(parameter int NUM_LEDS = 4, parameter int SLOW_HALF = 8, parameter int FAST_HALF = 3) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic link_up,
    input wire logic [1:0] link_speed,
    input wire logic tx_active,
    input wire logic rx_active,
    input wire logic collision,
    input wire logic [NUM_LEDS-1:0] led_out
);
    // Blink sequences below are unrolled for half periods of 8 and 3
    if (SLOW_HALF != 8 || FAST_HALF != 3) begin : g_bad_half
        $error("blink checks need half periods of 8 and 3");
    end
    localparam logic [31:0] WM = {4{LSEL_LANE_WMASK}};
    logic [31:0] ctrl;
    logic wr_pend;
    logic plain;
    // Shadow of the control word built from observed writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= LSEL_CTRL_RESET;
            wr_pend <= 1'b0;
        end else begin
            wr_pend <= hsel && htrans[1] && hready && hwrite && haddr[7:0] == LSEL_ADDR_CTRL;
            if (wr_pend) begin
                ctrl <= (ctrl & ~WM) | (hwdata & WM);
            end
        end
    end
    // Lane 0 with neither inversion nor blink
    assign plain = !ctrl[6] && !ctrl[7];
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_lit8; led_out[0] [*8]; endsequence
    sequence s_lit3; led_out[1] [*3]; endsequence
    property p_link_up; plain && ctrl[3:0] == LSEL_M_LINK_UP |=> led_out[0] == $past(link_up);
    endproperty
    property p_l10_1000; plain && ctrl[3:0] == LSEL_M_LINK_10_1000 |=> led_out[0] ==
        $past(link_up && (link_speed == LSEL_SPD_10 || link_speed == LSEL_SPD_1000));
    endproperty
    property p_l1000; plain && ctrl[3:0] == LSEL_M_LINK_1000 |=> led_out[0] ==
        $past(link_up && link_speed == LSEL_SPD_1000);
    endproperty
    property p_coll; plain && ctrl[3:0] == LSEL_M_COLLISION |=> led_out[0] == $past(collision);
    endproperty
    property p_act; plain && ctrl[3:0] == LSEL_M_ACTIVITY |=> led_out[0] ==
        $past(link_up && (tx_active || rx_active));
    endproperty
    property p_resv; plain && ctrl[3:0] == LSEL_M_RESERVED |=> !led_out[0]; endproperty
    property p_const; !ctrl[7] && ctrl[3:0] == LSEL_M_CONST_HIGH |=> led_out[0] == !$past(ctrl[6]);
    endproperty
    property p_blink_slow; ctrl[7:5] == 3'h4 && ctrl[3:0] == LSEL_M_CONST_HIGH && $rose(led_out[0])
        |-> s_lit8 ##1 !led_out[0];
    endproperty
    property p_blink_fast; ctrl[15:13] == 3'h5 && ctrl[11:8] == LSEL_M_CONST_HIGH
        && $rose(led_out[1]) |-> s_lit3 ##1 !led_out[1];
    endproperty
    a_link_up: assert property (p_link_up) else $error("link led wrong");
    a_l10_1000: assert property (p_l10_1000) else $error("10/1000 led wrong");
    a_l1000: assert property (p_l1000) else $error("1000 led wrong");
    a_coll: assert property (p_coll) else $error("collision led wrong");
    a_act: assert property (p_act) else $error("activity led wrong");
    a_resv: assert property (p_resv) else $error("reserved mode lit");
    a_const: assert property (p_const) else $error("constant led wrong");
    a_blink_slow: assert property (p_blink_slow) else $error("slow blink wrong");
    a_blink_fast: assert property (p_blink_fast) else $error("fast blink wrong");
endmodule

/* tb/lsel_led_board.sv */
// Board LED model counting how often each lamp lights up
`timescale 1ns/10ps
module lsel_led_board (
    input wire logic hclk,
    input wire logic clr,
    input wire logic [3:0] led,
    output logic [31:0] rises
);
    logic [3:0] prev = 4'h0;
    // Count turn-on events per lamp
    always @(posedge hclk) begin
        prev <= led;
        for (int i = 0; i < 4; i++) begin
            if (clr) begin
                rises[i*8 +: 8] <= 8'h00;
            end else if (led[i] && !prev[i]) begin
                rises[i*8 +: 8] <= rises[i*8 +: 8] + 8'h01;
            end
        end
    end
endmodule

/* tb/tb_top.sv */
// Testbench of the LED source selector
`timescale 1ns/10ps
module tb_top;
    import lsel_pkg::*;
    localparam int SLOW = 8;
    localparam int FAST = 3;
    localparam int WIN = 96;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [9:0] inp = 10'h000;
    logic clr = 1'b0;
    logic [31:0] rd;
    wire hready;
    wire hresp;
    wire [31:0] hrdata;
    wire [3:0] led_out;
    wire [31:0] rises;
    int num_errors = 0;
    int n_compared = 0;
    int cyc = 0;
    // Clock of 50 ns
    always #25 hclk = ~hclk;
    lsel_led_source_select #(.NUM_LEDS(4), .SLOW_HALF(SLOW), .FAST_HALF(FAST)) dut_u (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
        .hresp(hresp), .hrdata(hrdata), .link_up(inp[9]), .link_speed(inp[8:7]),
        .full_duplex(inp[6]), .tx_active(inp[5]), .rx_active(inp[4]), .filt_active(inp[3]),
        .collision(inp[2]), .bus_x1(inp[1]), .tx_paused(inp[0]), .led_out(led_out));
    lsel_led_board board_u (.hclk(hclk), .clr(clr), .led(led_out), .rises(rises));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One AHB-Lite single transfer, read data left in rd
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    function automatic logic exp_src(input logic [3:0] m, input logic [9:0] v);
        logic lu;
        logic [1:0] sp;
        logic act;
        lu = v[9];
        sp = v[8:7];
        act = v[5] | v[4];
        case (m)
            4'h0: exp_src = lu & (sp == LSEL_SPD_10 || sp == LSEL_SPD_1000);
            4'h1: exp_src = lu & (sp == LSEL_SPD_100 || sp == LSEL_SPD_1000);
            4'h2: exp_src = lu;
            4'h3: exp_src = lu & v[3];
            4'h4: exp_src = lu & !act;
            4'h5: exp_src = lu & (sp == LSEL_SPD_10);
            4'h6: exp_src = lu & (sp == LSEL_SPD_100);
            4'h7: exp_src = lu & (sp == LSEL_SPD_1000);
            4'h9: exp_src = v[6];
            4'hA: exp_src = v[2];
            4'hB: exp_src = lu & act;
            4'hC: exp_src = v[1];
            4'hD: exp_src = v[0];
            4'hE: exp_src = 1'b1;
            default: exp_src = 1'b0;
        endcase
    endfunction
    task t_regs;
        xfer(1'b0, LSEL_ADDR_CTRL, 32'h0);
        chk(rd, LSEL_CTRL_RESET);
        chk({31'h0, hresp}, 32'h0);
        xfer(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h0);
        @(posedge hclk);
        inp <= 10'h340;
        xfer(1'b0, LSEL_ADDR_STAT, 32'h0);
        chk(rd & 32'h0003_FF0F, 32'h0000_0D09);
        $display("t_regs done");
    endtask
    // Every mode on all four lanes against every input pattern
    task t_modes;
        logic e;
        for (int m = 0; m < 16; m++) begin
            xfer(1'b1, LSEL_ADDR_CTRL, {4{4'h0, m[3:0]}});
            for (int v = 0; v < 1024; v++) begin
                @(posedge hclk);
                inp <= v[9:0];
                @(posedge hclk);
                #1;
                e = exp_src(m[3:0], v[9:0]);
                chk({28'h0, led_out}, {28'h0, {4{e}}});
            end
        end
        $display("t_modes done");
    endtask
    task t_blink;
        xfer(1'b1, LSEL_ADDR_CTRL, 32'h0E0E_0E0E);
        xfer(1'b1, LSEL_ADDR_CTRL, 32'hCF5F_AE9E);
        xfer(1'b0, LSEL_ADDR_CTRL, 32'h0);
        chk(rd, 32'hCF4F_AE8E);
        // Second pass: live filtered activity and activity sources blinking on lanes 1 and 3, no inversion with blink
        for (int p = 0; p < 2; p++) begin
            if (p == 1) begin
                @(posedge hclk);
                inp <= 10'h3FF;
                xfer(1'b1, LSEL_ADDR_CTRL, 32'h8B4F_A38E);
                xfer(1'b0, LSEL_ADDR_STAT, 32'h0);
                chk(rd & 32'h0003_FF00, 32'h0003_FF00);
            end
            @(posedge hclk);
            clr <= 1'b1;
            @(posedge hclk);
            clr <= 1'b0;
            repeat (WIN) @(posedge hclk);
            #1;
            chk(rises, {8'(WIN / (2 * SLOW)), 8'h00, 8'(WIN / (2 * FAST)), 8'(WIN / (2 * SLOW))});
            chk({31'h0, led_out[2]}, 32'h1);
        end
        $display("t_blink done");
    endtask
    task complete_run;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            num_errors++;
            complete_run;
        end
    end
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs;
        t_modes;
        t_blink;
        complete_run;
    end
endmodule
bind lsel_led_source_select lsel_properties
    #(.NUM_LEDS(NUM_LEDS), .SLOW_HALF(SLOW_HALF), .FAST_HALF(FAST_HALF)) chk_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .link_up(link_up),
    .link_speed(link_speed), .tx_active(tx_active), .rx_active(rx_active),
    .collision(collision), .led_out(led_out));
